// ---- pd_pkg.sv ----
// Purpose: shared constants of the PN dither and CIC decimator
// Assumes: 24-bit fractional samples, 2^0 is the sign bit
// Notes:   register byte address is four times its index
package pd_pkg;
    // ------------------------------------------------------
    // Datapath
    // ------------------------------------------------------
    localparam int DATA_W  = 24;
    localparam int BUS_W   = 69;
    localparam int MAX_ORD = 5;
    localparam int MAX_SH  = 47;
    localparam int EXP_W   = 4;
    localparam int PN_LSB  = 5;
    localparam int LFSR_W  = 23;
    localparam int LFSR_TP = 17;
    localparam int INT_W [MAX_ORD] = '{69, 62, 53, 44, 34};

    // ------------------------------------------------------
    // Register indices
    // ------------------------------------------------------
    localparam logic [7:0] FILT_IDX  = 8'h01;
    localparam logic [7:0] CHCFG_IDX = 8'h05;
    localparam logic [7:0] PNSCL_IDX = 8'h10;
    localparam logic [7:0] DECIM_IDX = 8'h11;
    localparam logic [7:0] STAT_IDX  = 8'h12;

    // ------------------------------------------------------
    // Fields, masks, reset values, responses
    // ------------------------------------------------------
    localparam int BYP_BIT = 15;
    localparam int ORD_LSB = 0;
    localparam int SH_LSB  = 20;
    localparam int IDX_LSB = 2;
    localparam logic [31:0] FILT_MASK  = 32'h0000_8007;
    localparam logic [31:0] CHCFG_MASK = 32'h03F0_0000;
    localparam logic [31:0] HALF_MASK  = 32'h0000_FFFF;
    localparam logic [31:0] REG_RST    = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLV   = 2'h2;
endpackage : pd_pkg

// ---- pd_top.sv ----
// Purpose: PN dither, pre-shift and CIC decimator, I and Q
// Assumes: mixer and exponent inputs share aclk
// Notes:   AXI4-Lite registers, output through small buffer
// Functional notes
// [RULE1] Pseudonoise may be added to mixer I/Q before shifter and filter.
// [RULE2] One noise bit per sample, multiplied by a 16-bit scale.
// [RULE3] Noise amplitude spans zero to one quarter full scale.
// [RULE4] Scale zero adds nothing, disabling noise.
// [RULE5] Smallest non-zero noise step is 2^-18 of full scale per axis.
// [RULE6] Noise bit is sign over 2^0..2^-2; scale weights 2^-3..2^-18.
// [RULE7] Each comb delays by exactly one decimated sample.
// [RULE8] N integrators at input rate, decimate by R, N combs after.
// [RULE9] Filter order is programmable from zero to five.
// [RULE10] Filter register bit 15 bypasses the CIC entirely.
// [RULE11] Shift equals programmed code plus incoming exponent bits.
// [RULE12] Integrators 69,62,53,44,34 bits; combs all 24 bits.
// [RULE13] Input sits in low 24 bits of a 69-bit bus.
// [RULE14] Shifter moves 0 to 47 places, code in bits 25:20.
// [RULE15] Gain is R^N, no compensation beyond the pre-shift.
// [RULE16] Software sets pre_filter_shift_setting from 45, R^N and exponent sum.
// [RULE17] With bypass, software sets pre_filter_shift_setting to 45 minus exponent sum.
// [RULE18] Software keeps total shift at most 45, else MSBs drop.
// [RULE19] Software limits decimation per order to avoid overflow.
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pd_top #(
    parameter int          BUF_DEPTH = 2,
    parameter logic [22:0] PN_SEED   = 23'h000001
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [9:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [9:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        in_valid,
    output logic             in_ready,
    input  wire logic [23:0] in_i,
    input  wire logic [23:0] in_q,
    input  wire logic [3:0]  in_exp,
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic [23:0]      out_i,
    output logic [23:0]      out_q
);
    localparam int PW = $clog2(BUF_DEPTH);
    localparam int CW = $clog2(BUF_DEPTH + 1);

    // ------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------
    if (BUF_DEPTH < 2 || BUF_DEPTH > 16) begin : g_chk
        $error("BUF_DEPTH must lie in 2..16");
    end

    // ------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------
    function automatic logic mapped(input logic [7:0] idx);
        return idx inside {pd_pkg::FILT_IDX, pd_pkg::CHCFG_IDX,
            pd_pkg::PNSCL_IDX, pd_pkg::DECIM_IDX, pd_pkg::STAT_IDX};
    endfunction : mapped

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] d, input logic [3:0] s);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                m[8*i +: 8] = d[8*i +: 8];
            end
        end
        return m;
    endfunction : merge

    // ------------------------------------------------------
    // Register bus
    // ------------------------------------------------------
    logic        aw_have_reg, aw_have_next;
    logic [7:0]  aw_idx_reg,  aw_idx_next;
    logic        w_have_reg,  w_have_next;
    logic [31:0] wdata_reg,   wdata_next;
    logic [3:0]  wstrb_reg,   wstrb_next;
    logic        bvalid_reg,  bvalid_next;
    logic [1:0]  bresp_reg,   bresp_next;
    logic        rvalid_reg,  rvalid_next;
    logic [31:0] rdata_reg,   rdata_next;
    logic [1:0]  rresp_reg,   rresp_next;
    logic [31:0] filt_reg,    filt_next;
    logic [31:0] chcfg_reg,   chcfg_next;
    logic [31:0] pnscl_reg,   pnscl_next;
    logic [31:0] decim_reg,   decim_next;
    logic [15:0] out_cnt_reg, out_cnt_next;
    logic [CW-1:0] cnt_reg,   cnt_next;
    logic        do_wr;
    logic [7:0]  ar_idx;

    // One held address and one held word; no new write until answered
    assign awready = !aw_have_reg;
    assign wready  = !w_have_reg;
    assign arready = !rvalid_reg;
    assign do_wr   = aw_have_reg && w_have_reg && !bvalid_reg;
    assign ar_idx  = araddr[pd_pkg::IDX_LSB +: 8];
    assign bvalid  = bvalid_reg;
    assign bresp   = bresp_reg;
    assign rvalid  = rvalid_reg;
    assign rdata   = rdata_reg;
    assign rresp   = rresp_reg;

    // Next state of bus and configuration
    always_comb begin
        aw_have_next = aw_have_reg;
        aw_idx_next  = aw_idx_reg;
        w_have_next  = w_have_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        filt_next    = filt_reg;
        chcfg_next   = chcfg_reg;
        pnscl_next   = pnscl_reg;
        decim_next   = decim_reg;
        if (awvalid && awready) begin
            aw_have_next = 1'b1;
            aw_idx_next  = awaddr[pd_pkg::IDX_LSB +: 8];
        end
        if (wvalid && wready) begin
            w_have_next = 1'b1;
            wdata_next  = wdata;
            wstrb_next  = wstrb;
        end
        if (bvalid_reg && bready) begin
            bvalid_next = 1'b0;
        end
        if (do_wr) begin
            aw_have_next = 1'b0;
            w_have_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = mapped(aw_idx_reg) ? pd_pkg::RESP_OKAY
                                              : pd_pkg::RESP_SLV;
            case (aw_idx_reg)
                pd_pkg::FILT_IDX: begin
                    filt_next = merge(filt_reg, wdata_reg, wstrb_reg)
                              & pd_pkg::FILT_MASK;
                end
                pd_pkg::CHCFG_IDX: begin
                    chcfg_next = merge(chcfg_reg, wdata_reg, wstrb_reg)
                               & pd_pkg::CHCFG_MASK;
                end
                pd_pkg::PNSCL_IDX: begin
                    pnscl_next = merge(pnscl_reg, wdata_reg, wstrb_reg)
                               & pd_pkg::HALF_MASK;
                end
                pd_pkg::DECIM_IDX: begin
                    decim_next = merge(decim_reg, wdata_reg, wstrb_reg)
                               & pd_pkg::HALF_MASK;
                end
                default: ;
            endcase
        end
        if (rvalid_reg && rready) begin
            rvalid_next = 1'b0;
        end
        if (arvalid && arready) begin
            rvalid_next = 1'b1;
            rresp_next  = mapped(ar_idx) ? pd_pkg::RESP_OKAY
                                         : pd_pkg::RESP_SLV;
            case (ar_idx)
                pd_pkg::FILT_IDX:  rdata_next = filt_reg;
                pd_pkg::CHCFG_IDX: rdata_next = chcfg_reg;
                pd_pkg::PNSCL_IDX: rdata_next = pnscl_reg;
                pd_pkg::DECIM_IDX: rdata_next = decim_reg;
                pd_pkg::STAT_IDX:  rdata_next = {11'h000, 5'(cnt_reg),
                                                 out_cnt_reg};
                default:           rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Bus and configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            aw_idx_reg  <= 8'h00;
            w_have_reg  <= 1'b0;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= pd_pkg::RESP_OKAY;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= pd_pkg::RESP_OKAY;
            filt_reg    <= pd_pkg::REG_RST;
            chcfg_reg   <= pd_pkg::REG_RST;
            pnscl_reg   <= pd_pkg::REG_RST;
            decim_reg   <= pd_pkg::REG_RST;
        end else begin
            aw_have_reg <= aw_have_next;
            aw_idx_reg  <= aw_idx_next;
            w_have_reg  <= w_have_next;
            wdata_reg   <= wdata_next;
            wstrb_reg   <= wstrb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
            filt_reg    <= filt_next;
            chcfg_reg   <= chcfg_next;
            pnscl_reg   <= pnscl_next;
            decim_reg   <= decim_next;
        end
    end

    // ------------------------------------------------------
    // Stream control
    // ------------------------------------------------------
    logic [22:0] lfsr_reg, lfsr_next;
    logic [15:0] dec_reg,  dec_next;
    logic        bypass, adv, tick;
    logic [2:0]  ord, eff_ord;
    logic [6:0]  sh_sum;
    logic [5:0]  sh_amt;
    logic [23:0] res [2];

    // Orders above five behave as five
    assign ord     = (filt_reg[2:0] > 3'h5) ? 3'h5           // [RULE9]
                   : filt_reg[pd_pkg::ORD_LSB +: 3];
    assign bypass  = filt_reg[pd_pkg::BYP_BIT];               // [RULE10]
    assign eff_ord = bypass ? 3'h0 : ord;
    assign sh_sum  = {1'b0, chcfg_reg[pd_pkg::SH_LSB +: 6]}
                   + {3'h0, in_exp};                          // [RULE11]
    // Clamped at the shifter end; beyond 45 the top bits already fall off
    assign sh_amt  = (sh_sum > 7'(pd_pkg::MAX_SH))            // [RULE14]
                   ? 6'(pd_pkg::MAX_SH) : sh_sum[5:0];
    assign in_ready = (cnt_reg != CW'(BUF_DEPTH));
    assign adv      = in_valid && in_ready;
    // Every accepted sample leaves when bypassed, else one in R
    assign tick     = adv && (bypass || dec_reg == decim_reg[15:0]); // [RULE8]

    // Next noise state and decimation phase
    always_comb begin
        lfsr_next    = lfsr_reg;
        dec_next     = dec_reg;
        out_cnt_next = out_cnt_reg;
        if (adv) begin
            lfsr_next = {lfsr_reg[21:0],                      // [RULE2]
                lfsr_reg[pd_pkg::LFSR_W-1] ^ lfsr_reg[pd_pkg::LFSR_TP]};
            dec_next  = tick ? 16'h0000 : dec_reg + 16'h0001;
        end
        if (tick) begin
            out_cnt_next = out_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lfsr_reg    <= PN_SEED;
            dec_reg     <= 16'h0000;
            out_cnt_reg <= 16'h0000;
        end else begin
            lfsr_reg    <= lfsr_next;
            dec_reg     <= dec_next;
            out_cnt_reg <= out_cnt_next;
        end
    end

    // ------------------------------------------------------
    // Per-axis dither, shifter, integrators, combs
    // ------------------------------------------------------
    for (genvar a = 0; a < 2; a++) begin : g_ax
        logic signed [23:0] din, noise, dith;
        logic signed [24:0] sum;
        logic [68:0] tap [6];
        logic [23:0] cmb [6];

        // Saturating add keeps the dither from wrapping a full-scale sample
        always_comb begin
            din   = (a == 0) ? in_i : in_q;
            noise = {3'h0, pnscl_reg[15:0], 5'h00};           // [RULE6] [RULE3]
            if (lfsr_reg[a]) begin
                noise = -noise;                               // [RULE2]
            end
            sum = 25'(din) + 25'(noise);                      // [RULE1] [RULE4] [RULE5]
            if (sum[24] != sum[23]) begin
                dith = sum[24] ? 24'h800000 : 24'h7FFFFF;
            end else begin
                dith = sum[23:0];
            end
        end

        // Sample in low bits of the wide bus, then the pre-shift
        assign tap[0] = 69'(dith) << sh_amt;                  // [RULE13] [RULE14]

        for (genvar k = 1; k <= pd_pkg::MAX_ORD; k++) begin : g_st
            localparam int W = pd_pkg::INT_W[k-1];            // [RULE12]
            logic [W-1:0] acc_reg, acc_next;
            // Idle stages hold zero so a later order change starts clean
            always_comb begin
                acc_next = acc_reg;
                if (k > eff_ord) begin
                    acc_next = '0;
                end else if (adv) begin
                    acc_next = acc_reg + tap[k-1][68 -: W];   // [RULE8]
                end
            end
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    acc_reg <= '0;
                end else begin
                    acc_reg <= acc_next;
                end
            end
            assign tap[k] = (k > eff_ord) ? tap[k-1]          // [RULE9]
                          : 69'(acc_reg) << (69 - W);
        end

        assign cmb[0] = tap[pd_pkg::MAX_ORD][68 -: 24];

        for (genvar j = 1; j <= pd_pkg::MAX_ORD; j++) begin : g_cb
            logic [23:0] dly_reg, dly_next;
            always_comb begin
                dly_next = dly_reg;
                if (j > eff_ord) begin
                    dly_next = 24'h000000;
                end else if (tick) begin
                    dly_next = cmb[j-1];                      // [RULE7]
                end
            end
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    dly_reg <= 24'h000000;
                end else begin
                    dly_reg <= dly_next;
                end
            end
            assign cmb[j] = (j > eff_ord) ? cmb[j-1]
                          : cmb[j-1] - dly_reg;               // [RULE7] [RULE12]
        end

        // Raw R^N gain passes on; no trim after the combs
        assign res[a] = cmb[pd_pkg::MAX_ORD];                 // [RULE15]
    end

    // ------------------------------------------------------
    // Output buffer
    // ------------------------------------------------------
    logic [47:0]   mem_reg [BUF_DEPTH];
    logic [47:0]   mem_next [BUF_DEPTH];
    logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic          pop;

    assign out_valid = (cnt_reg != '0);
    assign pop       = out_valid && out_ready;
    assign out_i     = mem_reg[rp_reg][47:24];
    assign out_q     = mem_reg[rp_reg][23:0];

    // A push needs in_ready, so a full buffer stalls the input
    always_comb begin
        mem_next = mem_reg;
        wp_next  = wp_reg;
        rp_next  = rp_reg;
        cnt_next = cnt_reg;
        if (tick) begin
            mem_next[wp_reg] = {res[0], res[1]};
            wp_next = (wp_reg == PW'(BUF_DEPTH - 1)) ? '0 : wp_reg + 1'b1;
        end
        if (pop) begin
            rp_next = (rp_reg == PW'(BUF_DEPTH - 1)) ? '0 : rp_reg + 1'b1;
        end
        cnt_next = cnt_reg + CW'(tick) - CW'(pop);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < BUF_DEPTH; i++) begin
                mem_reg[i] <= 48'h0;
            end
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            mem_reg <= mem_next;
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    // ------------------------------------------------------
    // Assertions
    // ------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    pn_off_a: assert property (pnscl_reg[15:0] == 16'h0000 // [RULE4]
        |-> g_ax[0].noise == 24'h000000 && g_ax[1].noise == 24'h000000)
        else $error("noise present with zero scale");
    pn_step_a: assert property (!lfsr_reg[0] // [RULE6]
        |-> g_ax[0].noise == {3'h0, pnscl_reg[15:0], 5'h00})
        else $error("noise weighting wrong");
    shift_sum_a: assert property (sh_sum <= 7'h2F // [RULE11]
        |-> sh_amt == sh_sum[5:0])
        else $error("shift not code plus exponent");
    bypass_out_a: assert property (adv && bypass && !out_valid // [RULE10]
        |=> out_valid)
        else $error("bypassed sample not output");
    dec_phase_a: assert property (adv && !bypass && dec_reg != decim_reg[15:0] // [RULE8]
        |-> !tick ##1 dec_reg == $past(dec_reg) + 16'h0001)
        else $error("decimation phase slipped");
    comb_dly_a: assert property (tick && eff_ord != 3'h0 // [RULE7]
        |=> g_ax[0].g_cb[1].dly_reg == $past(g_ax[0].cmb[0]))
        else $error("comb delay not one sample");
    idle_stage_a: assert property (eff_ord < 3'h5 // [RULE9]
        |=> g_ax[0].g_st[5].acc_reg == '0)
        else $error("unused integrator active");
    full_stall_a: assert property (cnt_reg == CW'(BUF_DEPTH)
        |-> !in_ready ##1 cnt_reg <= CW'(BUF_DEPTH))
        else $error("buffer overrun");
    wr_resp_a: assert property (do_wr
        |=> bvalid and (!bready |=> bvalid && $stable(bresp)))
        else $error("write answer lost");
endmodule : pd_top

// ---- pd_peer.sv ----
// Purpose: mixer source and FIR-stage sink facing the block's stream
// Assumes: the bench queues samples with send and sets stall
// Notes:   idle I and Q data lines toggle so stale values never look valid
`timescale 1ns/1ps
module pd_peer (
    input  wire logic   aclk,
    input  wire logic   aresetn,
    input  wire logic   in_ready,
    output logic        in_valid,
    output logic [23:0] in_i,
    output logic [23:0] in_q,
    output logic [3:0]  in_exp,
    output logic        out_ready
);
    // ------------------------------------
    // Sample queue and sink stall
    // ------------------------------------
    logic [51:0] tx [$];
    logic        stall = 1'b0;

    task automatic send(input logic [51:0] s);
        tx.push_back(s);
    endtask : send

    // A sample is held until the edge where in_ready is high
    always @(posedge aclk) begin
        out_ready <= !stall;
        if (!aresetn) begin
            in_valid <= 1'b0;
            {in_exp, in_i, in_q} <= 52'h0;
        end else if (!in_valid || in_ready) begin
            in_valid <= tx.size() > 0;
            if (tx.size() > 0) begin
                {in_exp, in_i, in_q} <= tx.pop_front();
            end else begin
                in_i <= ~in_i; // Released I and Q lines change every cycle
                in_q <= ~in_q;
            end
        end
    end
endmodule : pd_peer

// ---- pd_top_tb.sv ----
// Purpose: self-checking bench of the dither, shifter and CIC block
// Assumes: registers over AXI4-Lite, stream through the peer model
// Notes:   configuration changes only while the stream is idle
`timescale 1ns/1ps
module pd_top_tb;
    // ------------------------------------
    // Signals, clock, design and peer
    // ------------------------------------
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, in_valid, in_ready;
    logic        out_valid, out_ready;
    logic [9:0]  awaddr = 10'h000, araddr = 10'h000;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0]  wstrb = 4'hF, in_exp;
    logic [1:0]  bresp, rresp;
    logic [23:0] in_i, in_q, out_i, out_q, rx [$], rxq [$];
    int          n_errors = 0, checked = 0;

    // 50 MHz clock
    initial begin
        forever #10 aclk = ~aclk;
    end

    pd_top i_pd_top (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .in_valid, .in_ready, .in_i, .in_q, .in_exp,
        .out_valid, .out_ready, .out_i, .out_q);
    pd_peer i_pd_peer (.aclk, .aresetn, .in_ready, .in_valid, .in_i, .in_q, .in_exp,
        .out_ready);

    // Every word the sink accepts, in order
    always @(posedge aclk) begin
        if (out_valid && out_ready) begin
            rx.push_back(out_i);
            rxq.push_back(out_q);
        end
    end

    // ------------------------------------
    // Shared tasks
    // ------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish;
        if (n_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic limit(input int n, input int lim);
        if (n >= lim) begin
            n_errors++;
            tally_and_finish();
        end
    endtask : limit

    // One write or one read; each channel released at the edge it is taken
    task automatic bus(input logic w, input logic [7:0] ix, input logic [31:0] din,
                       input logic [1:0] er, output logic [31:0] d);
        logic ta, tw, tr, tb;
        logic [1:0] r;
        int n;
        @(posedge aclk);
        awaddr <= {ix, 2'b00};
        araddr <= {ix, 2'b00};
        wdata <= din;
        awvalid <= w;
        wvalid <= w;
        bready <= w;
        arvalid <= !w;
        rready <= !w;
        for (n = 0; n < 50; n++) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tr = arvalid && arready;
            tb = w ? bvalid : rvalid;
            r = w ? bresp : rresp;
            d = rdata;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tr) arvalid <= 1'b0;
            if (tb) break;
        end
        bready <= 1'b0;
        rready <= 1'b0;
        limit(n, 50);
        chk(r, er);
    endtask : bus

    task automatic cfg(input logic [31:0] f, c, dm, pn);
        logic [31:0] d;
        bus(1'b1, pd_pkg::FILT_IDX, f, 2'h0, d);
        bus(1'b1, pd_pkg::CHCFG_IDX, c, 2'h0, d);
        bus(1'b1, pd_pkg::DECIM_IDX, dm, 2'h0, d);
        bus(1'b1, pd_pkg::PNSCL_IDX, pn, 2'h0, d);
        rx.delete();
        rxq.delete();
    endtask : cfg

    task automatic wait_rx(input int k);
        int n;
        for (n = 0; n < 5000 && rx.size() < k; n++) @(posedge aclk);
        limit(n, 5000);
    endtask : wait_rx

    // ------------------------------------
    // Scenarios
    // ------------------------------------
    task automatic t_regs;
        logic [7:0]  ix [4] = '{pd_pkg::FILT_IDX, pd_pkg::CHCFG_IDX, pd_pkg::PNSCL_IDX,
                                pd_pkg::DECIM_IDX};
        logic [31:0] mk [4] = '{32'h0000_8007, 32'h03F0_0000, 32'h0000_FFFF, 32'h0000_FFFF};
        logic [31:0] d;
        for (int k = 0; k < 4; k++) begin
            bus(1'b0, ix[k], 32'h0, 2'h0, d);
            chk(d, 32'h0000_0000);
            bus(1'b1, ix[k], 32'hFFFF_FFFF, 2'h0, d);
            bus(1'b0, ix[k], 32'h0, 2'h0, d);
            chk(d, mk[k]);
        end
        // Byte enables: only bits 23:20 of the shift code take this write
        wstrb <= 4'h4;
        bus(1'b1, pd_pkg::CHCFG_IDX, 32'h0, 2'h0, d);
        wstrb <= 4'hF;
        bus(1'b0, pd_pkg::CHCFG_IDX, 32'h0, 2'h0, d);
        chk(d, 32'h0300_0000);
        // Unmapped place answers with an error and reads zero
        bus(1'b1, 8'hFF, 32'hFFFF_FFFF, 2'h2, d);
        bus(1'b0, 8'hFF, 32'h0, 2'h2, d);
        chk(d, 32'h0000_0000);
    endtask : t_regs

    // Bypass: output is the top 24 bits of the shifted 69-bit bus
    task automatic t_shift;
        logic [57:0] tb [5] = '{{6'd43, 4'd2, 24'h123456, 24'h123456},
            {6'd45, 4'd0, 24'hFFFFFE, 24'hFFFFFE}, {6'd44, 4'd0, 24'hFFFFFE, 24'hFFFFFF},
            {6'd47, 4'd0, 24'h400001, 24'h000004}, {6'd46, 4'd4, 24'h000003, 24'h00000C}};
        for (int k = 0; k < 5; k++) begin
            cfg(32'h0000_8003, {6'h0, tb[k][57:52], 20'h0}, 0, 0);
            i_pd_peer.send({tb[k][51:24], tb[k][47:24]});
            wait_rx(1);
            chk(rx[0], tb[k][23:0]);
            chk(rxq[0], tb[k][23:0]);
        end
    endtask : t_shift

    // Orders 0..5 with R = order + 2; steady output is x * R^N / 2^ceil(log2 R^N)
    task automatic t_cic;
        int g, c;
        for (int nn = 0; nn <= 5; nn++) begin
            g = (nn + 2) ** nn;
            c = $clog2(g);
            cfg(nn, (45 - c) << 20, nn + 1, 0);
            repeat (12 * (nn + 2)) i_pd_peer.send({4'h0, 24'h100000, 24'h100000});
            wait_rx(12);
            repeat (8) @(posedge aclk);
            chk(rx.size(), 12);
            chk(rx[11], 24'((64'h100000 * g) >> c));
            chk(rxq[11], 24'((64'h100000 * g) >> c));
        end
    endtask : t_cic

    // Dither on zero input; the sink stalls first so the buffer fills and refuses
    task automatic t_dither;
        logic [15:0] sc [2] = '{16'h0001, 16'hFFFF};
        logic [23:0] m;
        logic [31:0] d;
        int neg;
        for (int k = 0; k < 2; k++) begin
            cfg(32'h0000_8000, 45 << 20, 0, sc[k]);
            i_pd_peer.stall <= 1'b1;
            repeat (64) i_pd_peer.send(52'h0);
            repeat (20) @(posedge aclk);
            @(negedge aclk);
            chk(in_ready, 1'b0);
            bus(1'b0, pd_pkg::STAT_IDX, 32'h0, 2'h0, d);
            chk(d[20:16], 5'd2);
            chk(d[15:0], 16'(79 + 64 * k));
            i_pd_peer.stall <= 1'b0;
            wait_rx(64);
            neg = 0;
            for (int j = 0; j < 64; j++) begin
                m = rx[j][23] ? -rx[j] : rx[j];
                neg += rx[j][23];
                chk(m, {sc[k], 5'h00});
                m = rxq[j][23] ? -rxq[j] : rxq[j];
                chk(m, {sc[k], 5'h00});
            end
            chk(neg > 0 && neg < 64, 1'b1);
        end
    endtask : t_dither

    // Reset for five cycles, then the scenarios in turn
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_shift();
        t_cic();
        t_dither();
        tally_and_finish();
    end
endmodule : pd_top_tb
